// *** rtl/aurov_defines.vh ***
// register map and field constants for the aux result and overvoltage flag bank
`ifndef AUROV_DEFINES_VH
`define AUROV_DEFINES_VH

`define AUROV_ADDR_W          7
`define AUROV_DATA_W          16
`define AUROV_ADDR_REGULATOR  7'h4a
`define AUROV_ADDR_SECOND_REF 7'h4b
`define AUROV_ADDR_OV_LOW     7'h4d
`define AUROV_ADDR_OV_HIGH    7'h4e
`define AUROV_RESULT_W        14
`define AUROV_RESULT_PAD      2'h0
`define AUROV_RESET_WORD      16'h0000
`define AUROV_CLEAR_WORD      16'h0000
`define AUROV_LOW_CELLS       16
`define AUROV_HIGH_PAD        15'h0000

`endif

// *** rtl/aurov_flag_bank.v ***
// sticky overvoltage flag bank with write-zero clear
`timescale 1ns/1ps
module aurov_flag_bank #(
  parameter WIDTH = 16
) (
  input  wire             i_clk,
  input  wire             i_sys_rst,
  input  wire             i_ce,
  input  wire [WIDTH-1:0] i_detect,
  input  wire             i_clear,
  output wire [WIDTH-1:0] o_flags
);

  reg [WIDTH-1:0] flags_reg;
  genvar          g;

  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_flag
      always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          flags_reg[g] <= 1'b0;
        end else if (i_ce) begin
          if (i_detect[g]) begin
            flags_reg[g] <= 1'b1;
          end else if (i_clear) begin
            flags_reg[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign o_flags = flags_reg;

endmodule // aurov_flag_bank

// *** rtl/aurov_bank.v ***
// aux result registers and cell overvoltage flag registers
`timescale 1ns/1ps
`include "aurov_defines.vh"
module aurov_bank (
  input  wire                      i_clk,
  input  wire                      i_sys_rst,
  input  wire                      i_ce,
  input  wire                      i_rd,
  input  wire                      i_wr,
  input  wire [`AUROV_ADDR_W-1:0]  i_addr,
  input  wire [`AUROV_DATA_W-1:0]  i_wdata,
  output reg  [`AUROV_DATA_W-1:0]  o_rdata,
  input  wire                      i_regulator_valid,
  input  wire [`AUROV_RESULT_W-1:0] i_regulator_code,
  input  wire                      i_second_ref_valid,
  input  wire [`AUROV_RESULT_W-1:0] i_second_ref_code,
  input  wire [`AUROV_LOW_CELLS-1:0] i_overvoltage_low,
  input  wire                      i_cell17_overvoltage,
  output wire [`AUROV_LOW_CELLS-1:0] o_flags_low,
  output wire                      o_cell17_overvoltage_flag
);

  // ---------------------------------------------------------------
  // request qualification
  // ---------------------------------------------------------------
  wire                         rd_take;
  wire                         wr_take;
  wire                         hit_regulator;
  wire                         hit_second_ref;
  wire                         hit_ov_low;
  wire                         hit_ov_high;

  // a strobe seen while frozen is dropped, not delayed
  assign rd_take        = i_ce && i_rd;
  assign wr_take        = i_ce && i_wr;

  // one compare per mapped register
  assign hit_regulator  = (i_addr == `AUROV_ADDR_REGULATOR);
  assign hit_second_ref = (i_addr == `AUROV_ADDR_SECOND_REF);
  assign hit_ov_low     = (i_addr == `AUROV_ADDR_OV_LOW);
  assign hit_ov_high    = (i_addr == `AUROV_ADDR_OV_HIGH);

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // reserved bits 15 to 1 of the high word are not stored, but must be zero for a clear
  wire                         clear_word;
  wire                         clear_low;
  wire                         clear_high;

  // only an all-zero word clears; other values and result writes are ignored
  assign clear_word     = (i_wdata == `AUROV_CLEAR_WORD);
  assign clear_low      = wr_take && clear_word && hit_ov_low;
  assign clear_high     = wr_take && clear_word && hit_ov_high;

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  wire                         regulator_load;
  wire                         second_ref_load;

  // a load pulse seen while frozen is lost
  assign regulator_load  = i_ce && i_regulator_valid;
  assign second_ref_load = i_ce && i_second_ref_valid;

  // results hold the last converted code
  reg  [`AUROV_RESULT_W-1:0]   regulator_reg;
  reg  [`AUROV_RESULT_W-1:0]   regulator_next;
  reg  [`AUROV_RESULT_W-1:0]   second_ref_reg;
  reg  [`AUROV_RESULT_W-1:0]   second_ref_next;

  // the bus has no path into the results; only the converter loads them
  always @* begin
    regulator_next = regulator_reg;
    if (regulator_load) begin
      regulator_next = i_regulator_code;
    end
  end

  always @* begin
    second_ref_next = second_ref_reg;
    if (second_ref_load) begin
      second_ref_next = i_second_ref_code;
    end
  end

  // both results clear on reset and change only on a load pulse
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      regulator_reg <= {`AUROV_RESULT_W{1'b0}};
    end else begin
      regulator_reg <= regulator_next;
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      second_ref_reg <= {`AUROV_RESULT_W{1'b0}};
    end else begin
      second_ref_reg <= second_ref_next;
    end
  end

  // ---------------------------------------------------------------
  // detect mapping
  // ---------------------------------------------------------------
  wire [`AUROV_LOW_CELLS-1:0]  low_detect;
  wire [0:0]                   high_detect;
  genvar                       c;

  // detects are level signals from the comparators
  // cell n lands on bit n-1 of the low register
  generate
    for (c = 0; c < `AUROV_LOW_CELLS; c = c + 1) begin : g_cell
      assign low_detect[c] = i_overvoltage_low[c];
    end
  endgenerate

  // cell 17 sits alone in bit 0 of the high register
  assign high_detect[0] = i_cell17_overvoltage;

  // ---------------------------------------------------------------
  // flag registers
  // ---------------------------------------------------------------
  // low bank holds cells 1 to 16, high bank holds cell 17
  wire [`AUROV_LOW_CELLS-1:0]  low_flags;
  wire [0:0]                   high_flags;

  // a detect beats a same-cycle clear so that a live fault is never lost to a clear; detects are dropped while frozen
  aurov_flag_bank #(
    .WIDTH (`AUROV_LOW_CELLS)
  ) u_low (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_detect  (low_detect),
    .i_clear   (clear_low),
    .o_flags   (low_flags)
  );

  // each bank clears on its own address only
  aurov_flag_bank #(
    .WIDTH (1)
  ) u_high (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_detect  (high_detect),
    .i_clear   (clear_high),
    .o_flags   (high_flags)
  );

  // flags leave straight from their flip-flops
  assign o_flags_low               = low_flags;
  assign o_cell17_overvoltage_flag = high_flags[0];

  // ---------------------------------------------------------------
  // read words
  // ---------------------------------------------------------------
  // each word is built at full bus width
  wire [`AUROV_DATA_W-1:0]     regulator_word;
  wire [`AUROV_DATA_W-1:0]     second_ref_word;
  wire [`AUROV_DATA_W-1:0]     low_word;
  wire [`AUROV_DATA_W-1:0]     high_word;

  // result bits 15 and 14 are not stored and read as zero
  assign regulator_word  = {`AUROV_RESULT_PAD, regulator_reg};
  assign second_ref_word = {`AUROV_RESULT_PAD, second_ref_reg};
  // flag bits come back in cell order
  assign low_word        = low_flags;
  // reserved bits 15 to 1 hold nothing and read as zero
  assign high_word       = {`AUROV_HIGH_PAD, high_flags};

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  reg  [`AUROV_DATA_W-1:0]     read_word;
  reg  [`AUROV_DATA_W-1:0]     rdata_next;

  // unmapped addresses read as zero
  always @* begin
    read_word = `AUROV_RESET_WORD;
    if (hit_regulator) begin
      read_word = regulator_word;
    end else if (hit_second_ref) begin
      read_word = second_ref_word;
    end else if (hit_ov_low) begin
      read_word = low_word;
    end else if (hit_ov_high) begin
      read_word = high_word;
    end
  end

  // the last word read stands until the next taken read
  always @* begin
    rdata_next = o_rdata;
    if (rd_take) begin
      rdata_next = read_word;
    end
  end

  // registered read data, cleared on reset
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= `AUROV_RESET_WORD;
    end else begin
      o_rdata <= rdata_next;
    end
  end

endmodule // aurov_bank

// *** bench/aurov_bank_monitor.sv ***
// port checks for the flag bank
`timescale 1ns/1ps
module aurov_bank_monitor(input wire i_clk,i_sys_rst,i_ce,i_rd,i_wr,i_cell17_overvoltage,o_cell17_overvoltage_flag,
  input wire [6:0] i_addr,input wire [15:0] i_wdata,o_rdata,i_overvoltage_low,o_flags_low);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire r=i_ce&&i_rd,z=i_ce&&i_wr&&i_wdata==16'h0,l=i_addr==7'h4d,h=i_addr==7'h4e,f=o_cell17_overvoltage_flag;
  wire [15:0] v=i_overvoltage_low,q=o_flags_low;
  a_set_low: assert property (i_ce|=>(q&$past(v))==$past(v)) else $error("set");
  a_set_high: assert property (i_ce&&i_cell17_overvoltage|=>f) else $error("set17");
  a_flags_hold: assert property (!(z&&l)|=>(q&$past(q))==$past(q)) else $error("lost");
  a_clear_low: assert property (z&&l|=>q==$past(v)) else $error("clr");
  a_clear_high: assert property (z&&h|=>f==$past(i_cell17_overvoltage)) else $error("clr17");
  a_read_low: assert property (r&&l|=>o_rdata==$past(q)) else $error("rd");
  a_read_high: assert property (r&&h|=>o_rdata=={15'h0,$past(f)}) else $error("rd17");
  a_result_pad: assert property (r&&i_addr[6:1]==6'h25|=>o_rdata[15:14]==2'h0) else $error("pad");
  c_clear: cover property (z&&l&&q!=16'h0);
  c_read: cover property (r&&h&&f);
  c_hold: cover property (!z&&q!=16'h0);
  a_freeze_hold: assert property (!i_ce|=>q==$past(q)&&f==$past(f)&&o_rdata==$past(o_rdata)) else $error("frozen");
  c_set_wins: cover property (z&&l&&v!=16'h0);
endmodule // aurov_bank_monitor
bind aurov_bank aurov_bank_monitor monitor(.*);

// *** bench/aurov_host.sv ***
// host model issuing register strobes
`timescale 1ns/1ps
module aurov_host(input wire i_clk,output reg o_rd=0,o_wr=0,output reg [6:0] o_addr=0,output reg [15:0] o_wdata=0);
  task acc(input w,input [6:0] a,input [15:0] d);
    @(negedge i_clk) {o_rd,o_wr,o_addr,o_wdata}={~w,w,a,d};
    @(negedge i_clk) {o_rd,o_wr,o_wdata}={2'h0,~d};
  endtask
endmodule // aurov_host

// *** bench/aurov_bank_tb.sv ***
// flag bank bench
`timescale 1ns/1ps
module aurov_bank_tb;
  reg i_clk=0,i_sys_rst=1,i_ce=1,i_regulator_valid=0,i_second_ref_valid=0,i_cell17_overvoltage=0,e=0;
  reg [13:0] i_regulator_code=0,i_second_ref_code=0;
  reg [15:0] i_overvoltage_low=0,fl=0;
  wire i_rd,i_wr,o_cell17_overvoltage_flag;
  wire [6:0] i_addr;
  wire [15:0] i_wdata,o_rdata,o_flags_low;
  integer n_errors=0,checks_done=0,seed=7,i;
  aurov_bank dut(
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_rd(i_rd),
    .i_wr(i_wr),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .i_regulator_valid(i_regulator_valid),
    .i_regulator_code(i_regulator_code),
    .i_second_ref_valid(i_second_ref_valid),
    .i_second_ref_code(i_second_ref_code),
    .i_overvoltage_low(i_overvoltage_low),
    .i_cell17_overvoltage(i_cell17_overvoltage),
    .o_flags_low(o_flags_low),
    .o_cell17_overvoltage_flag(o_cell17_overvoltage_flag)
  );
  aurov_host host(.i_clk(i_clk),.o_rd(i_rd),.o_wr(i_wr),.o_addr(i_addr),.o_wdata(i_wdata));
  initial forever #25 i_clk=~i_clk;
  function [15:0] res(input [13:0] c); res={2'h0,c}; endfunction
  task check(input [15:0] seen,input [15:0] exp,input [8*16-1:0] name);
    checks_done++;
    if (seen!==exp) begin
      n_errors++;
      $display("wrong value %0s expected %h seen %h",name,exp,seen);
    end
  endtask
  task rdc(input [6:0] a,input [15:0] x);
    host.acc(0,a,16'h0);
    check(o_rdata,x,"o_rdata");
  endtask
  task give_verdict; $display("errors %0d checks %0d",n_errors,checks_done);
    if (n_errors==0&&checks_done>0) $display("verification passed"); else $display("verification failed");
    $finish; endtask
  initial begin #60000; n_errors++; give_verdict; end
  initial begin
    repeat (5) @(negedge i_clk);
    i_sys_rst=0;
    for (i=0;i<5;i++) rdc(7'h4a+i,16'h0);
    for (i=0;i<24;i++) begin
      {i_regulator_code,i_second_ref_code,i_overvoltage_low}={$random(seed),$random(seed)};
      {i_regulator_valid,i_second_ref_valid,i_cell17_overvoltage}={2'h3,i[0]};
      fl=fl|i_overvoltage_low; e=e|i[0];
      @(negedge i_clk) {i_regulator_valid,i_second_ref_valid,i_overvoltage_low,i_cell17_overvoltage}=0;
      host.acc(1,7'h4a+i%5,16'h8000);
      rdc(7'h4a,res(i_regulator_code));
      rdc(7'h4b,res(i_second_ref_code));
      rdc(7'h4d,fl);
      rdc(7'h4e,{15'h0,e});
      check(o_flags_low,fl,"o_flags_low");
      check({15'h0,o_cell17_overvoltage_flag},{15'h0,e},"o_cell17_flag");
      if (i%4==3) begin host.acc(1,7'h4d,16'h0); fl=0; end
      if (i%6==5) begin host.acc(1,7'h4e,16'h0); e=0; end
    end
    // corner: detect and clear in one cycle, then four frozen cycles
    host.acc(1,7'h4d,16'h0);
    host.acc(1,7'h4e,16'h0);
    {i_overvoltage_low,i_cell17_overvoltage}={16'h8001,1'b1};
    host.acc(1,7'h4d,16'h0);
    host.acc(1,7'h4e,16'h0);
    {i_overvoltage_low,i_cell17_overvoltage}=17'h0;
    rdc(7'h4d,16'h8001);
    rdc(7'h4e,16'h0001);
    i_ce=0;
    i_overvoltage_low=16'h7ffe;
    host.acc(1,7'h4d,16'h0);
    host.acc(0,7'h4b,16'h0);
    check(o_rdata,16'h0001,"rdata_frozen");
    check(o_flags_low,16'h8001,"flags_frozen");
    {i_ce,i_overvoltage_low}={1'b1,16'h0};
    host.acc(1,7'h4d,16'h0);
    host.acc(1,7'h4e,16'h0);
    check(o_flags_low,16'h0,"o_flags_low");
    check({15'h0,o_cell17_overvoltage_flag},16'h0,"o_cell17_flag");
    give_verdict;
  end
endmodule // aurov_bank_tb
